// File: logic/pdmc_defines.svh
// Constants of the power-down mode controller: offsets, fields, reset values, counts
//
// Behaviour
// R1 - Deep-sleep pin rising while init low: leave standby, reset, restart oscillator
// R2 - Outside party keeps init low after deep-sleep release until oscillator settles
// R3 - Init pin rising: run reset exception handling, then normal execution
// R4 - Outside party drives init low before driving deep-sleep low
// R5 - Halt bit set to 1 stops its unit at bus cycle end; CPU runs on
// R6 - Halt bit cleared to 0 restarts its unit at bus cycle end
// R7 - Stopped units keep state, except pulse, fine pulse, serial and two-wire units
// R8 - After reset every halt bit reads stopped; the clock-out halt bit resets to 0 (running) here
// R9 - Register access to a stopped unit is blocked
// R10 - Clock-out halt bit 1 stops clock output at cycle end, pin high
// R11 - Halt bit 0 with direction 1 drives system clock on the pin
// R12 - Direction 0 disables clock output, pin becomes an input
// R13 - Pin tristate when direction 0 or hardware standby; high in standby or halted
// R14 - Software standby keeps port output levels
// R15 - Software disables a unit's interrupts before halting it
// R16 - Only the processor writes the halt control registers
// R17 - Software keeps the divided system clock at or above 5 MHz
// R18 - Divide ratio changes peripheral clock, clock pin and wake wait
// R19 - Hardware standby holds all functions reset and ports high impedance
// R20 - Software picks a wake wait of 8192 to 262144 states above resonator settling
// R21 - Deep-sleep and init pins pass two flip-flops before the state machine
`ifndef PDMC_DEFINES_SVH
`define PDMC_DEFINES_SVH

// ==================================================================
// Register byte offsets
`define PDMC_OFS_HALT_A      8'h00
`define PDMC_OFS_HALT_B      8'h04
`define PDMC_OFS_CLK_CTRL    8'h08
`define PDMC_OFS_LOW_POWER   8'h0c
`define PDMC_OFS_STATUS      8'h10

// ==================================================================
// Field widths, positions and reset values
`define PDMC_HALT_A_W        16
`define PDMC_HALT_B_W        8
`define PDMC_UNITS           24
`define PDMC_HALT_A_RST      16'hffff
`define PDMC_HALT_B_RST      8'hff
`define PDMC_CLK_HALT_BIT    0
`define PDMC_PORT_DIR_BIT    1
`define PDMC_DIV_LSB         4
`define PDMC_WAKE_LSB        0
`define PDMC_SOFT_SBY_BIT    7
`define PDMC_CLK_HALT_RST    1'h0
`define PDMC_PORT_DIR_RST    1'h0
`define PDMC_DIV_RST         3'h0
`define PDMC_WAKE_RST        3'h0
`define PDMC_SOFT_SBY_RST    1'h0
`define PDMC_NO_RETAIN_RST   24'hff0000

// ==================================================================
// Timing counts
`define PDMC_WAKE_W          19
`define PDMC_WAKE_BASE       8192
`define PDMC_WAKE_SHORT      19'h10
`define PDMC_EXC_CYCLES      4'h8

`endif

// File: logic/pdmc_pkg.sv
// Types of the power-down mode controller
package pdmc_pkg;
    `include "pdmc_defines.svh"

    // Power processing states
    typedef enum logic [2:0] {
        PDMC_HW_STANDBY,
        PDMC_RESET_HOLD,
        PDMC_RESET_EXC,
        PDMC_RUN,
        PDMC_SW_STANDBY,
        PDMC_WAKE_WAIT
    } pdmc_state_e;

    // All state of the controller
    typedef struct packed {
        pdmc_state_e                 st;
        logic [1:0]                  sleep_s;
        logic [1:0]                  init_s;
        logic [1:0]                  phi_s;
        logic [`PDMC_HALT_A_W-1:0]   halt_a;
        logic [`PDMC_HALT_B_W-1:0]   halt_b;
        logic                        clk_halt;
        logic                        port_dir;
        logic [2:0]                  div_sel;
        logic [2:0]                  wake_sel;
        logic                        soft_sby;
        logic [2:0]                  div_cnt;
        logic                        phi;
        logic                        tick;
        logic [`PDMC_WAKE_W-1:0]     wait_cnt;
        logic [3:0]                  exc_cnt;
        logic                        dph_wr;
        logic [7:0]                  dph_addr;
        logic [31:0]                 rdata;
        logic [`PDMC_UNITS-1:0]      clear;
    } pdmc_regs_s;
endpackage

// File: logic/pdmc_top.sv
// Power-down mode controller: standby sequencing, unit halt, clock output gating
`timescale 1ns/100ps
`include "pdmc_defines.svh"
module pdmc_top #(
    parameter int                         WAKE_BASE      = `PDMC_WAKE_BASE,
    parameter logic [`PDMC_UNITS-1:0]     NO_RETAIN_MASK = `PDMC_NO_RETAIN_RST
) (
    // Clock and reset
    input  wire logic                     CLK,
    input  wire logic                     ARST_N,
    // AHB-Lite slave
    input  wire logic                     HSEL,
    input  wire logic [7:0]               HADDR,
    input  wire logic [1:0]               HTRANS,
    input  wire logic                     HWRITE,
    input  wire logic [2:0]               HSIZE,
    input  wire logic [31:0]              HWDATA,
    input  wire logic                     HREADY,
    output logic [31:0]                   HRDATA,
    output logic                          HREADYOUT,
    output logic                          HRESP,
    // Board pins
    input  wire logic                     DEEP_SLEEP_PIN_N,
    input  wire logic                     EXTERNAL_INIT_PIN_N,
    input  wire logic                     PHI_I,
    output logic                          PHI_O,
    output logic                          PHI_OE,
    // Processor events
    input  wire logic                     SLEEP_REQ,
    input  wire logic                     WAKE_IRQ,
    // System control
    output logic                          SYS_RESET_N,
    output logic                          RESET_EXC,
    output logic                          CPU_RUN,
    output logic                          OSC_EN,
    output logic                          PORT_HIZ,
    output logic                          PORT_HOLD,
    output logic                          PERIPH_TICK,
    // Per-unit control
    output logic [`PDMC_UNITS-1:0]        UNIT_HALT,
    output logic [`PDMC_UNITS-1:0]        UNIT_ACCESS_EN,
    output logic [`PDMC_UNITS-1:0]        UNIT_STATE_CLEAR
);
    import pdmc_pkg::*;

    pdmc_regs_s                r;
    pdmc_regs_s                n;
    logic [1:0]                rst_sync_r;
    logic                      rst_n;
    logic [`PDMC_UNITS-1:0]    clear_nxt;
    logic                      deep_sleep;
    logic                      init_n;
    logic                      addr_ok;
    logic [2:0]                div_lim;

    // ==================================================================
    // Reset release
    // Release is synchronised so no register leaves reset on a split edge
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'h1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ==================================================================
    // Wake wait length in divided-clock states
    function automatic logic [`PDMC_WAKE_W-1:0] wait_target(input logic [2:0] sel);
        logic [`PDMC_WAKE_W-1:0] base;
        base = `PDMC_WAKE_W'(WAKE_BASE);
        case (sel)
            3'h7: wait_target = `PDMC_WAKE_SHORT;
            3'h6: wait_target = base;  // Reserved code falls back to the shortest safe wait
            default: wait_target = base << sel;
        endcase
    endfunction

    // ==================================================================
    // Per-unit clear of non-retaining units
    genvar gi;
    generate
        for (gi = 0; gi < `PDMC_UNITS; gi++) begin : g_unit
            // Units without retention lose state while halted
            assign clear_nxt[gi] = NO_RETAIN_MASK[gi] & n.st == PDMC_RUN &
                                   (gi < `PDMC_HALT_A_W ? n.halt_a[gi % `PDMC_HALT_A_W]
                                   : n.halt_b[gi % `PDMC_HALT_B_W]);  // R7
        end
    endgenerate

    assign deep_sleep = ~r.sleep_s[1];
    assign init_n     = r.init_s[1];
    assign addr_ok    = HSEL & HTRANS[1] & HREADY;

    // ==================================================================
    // Next-state logic
    always_comb begin
        n = r;
        // Pins pass two flip-flops; only the second stage is read
        n.sleep_s = {r.sleep_s[0], DEEP_SLEEP_PIN_N};  // R21
        n.init_s  = {r.init_s[0], EXTERNAL_INIT_PIN_N};  // R21
        n.phi_s   = {r.phi_s[0], PHI_I};
        n.tick    = 1'h0;
        n.dph_wr  = 1'h0;

        // Power state machine; deep sleep outranks init, init outranks all else
        case (r.st)
            PDMC_HW_STANDBY: begin
                if (!deep_sleep) begin
                    n.st = PDMC_RESET_HOLD;  // R1
                end
            end
            PDMC_RESET_HOLD: begin
                if (init_n) begin
                    n.st      = PDMC_RESET_EXC;  // R3
                    n.exc_cnt = 4'h0;
                end
            end
            PDMC_RESET_EXC: begin
                if (r.exc_cnt == `PDMC_EXC_CYCLES - 4'h1) begin
                    n.st = PDMC_RUN;  // R3
                end else begin
                    n.exc_cnt = r.exc_cnt + 4'h1;
                end
            end
            PDMC_RUN: begin
                if (SLEEP_REQ && r.soft_sby) begin
                    n.st = PDMC_SW_STANDBY;
                end
            end
            PDMC_SW_STANDBY: begin
                if (WAKE_IRQ) begin
                    n.st       = PDMC_WAKE_WAIT;
                    n.wait_cnt = '0;
                end
            end
            PDMC_WAKE_WAIT: begin
                // Wait counts divided-clock states, so it scales with the ratio
                if (r.wait_cnt >= wait_target(r.wake_sel)) begin
                    n.st = PDMC_RUN;
                end else if (r.tick) begin
                    n.wait_cnt = r.wait_cnt + `PDMC_WAKE_W'(1);  // R18
                end
            end
            default: begin
                n.st = PDMC_HW_STANDBY;
            end
        endcase
        if (!init_n && r.st != PDMC_HW_STANDBY) begin
            n.st = PDMC_RESET_HOLD;
        end
        if (deep_sleep) begin
            n.st = PDMC_HW_STANDBY;  // R19
        end

        // Divided system clock; stops with the oscillator
        case (r.div_sel)
            3'h1: div_lim = 3'h1;
            3'h2: div_lim = 3'h3;
            default: div_lim = 3'h0;
        endcase
        if (r.st == PDMC_HW_STANDBY || r.st == PDMC_SW_STANDBY) begin
            n.div_cnt = 3'h0;
            n.phi     = 1'h0;
        end else if (r.div_cnt >= div_lim) begin
            n.div_cnt = 3'h0;
            n.phi     = ~r.phi;  // R18
            n.tick    = ~r.phi;
        end else begin
            n.div_cnt = r.div_cnt + 3'h1;
        end

        // Data phase write; takes effect at the end of the bus cycle
        if (r.dph_wr && r.st == PDMC_RUN) begin
            case (r.dph_addr)
                `PDMC_OFS_HALT_A: begin
                    n.halt_a = HWDATA[`PDMC_HALT_A_W-1:0];  // R5 R6
                end
                `PDMC_OFS_HALT_B: begin
                    n.halt_b = HWDATA[`PDMC_HALT_B_W-1:0];  // R5 R6
                end
                `PDMC_OFS_CLK_CTRL: begin
                    n.clk_halt = HWDATA[`PDMC_CLK_HALT_BIT];  // R10
                    n.port_dir = HWDATA[`PDMC_PORT_DIR_BIT];  // R12
                    n.div_sel  = HWDATA[`PDMC_DIV_LSB +: 3];  // R18
                end
                `PDMC_OFS_LOW_POWER: begin
                    n.wake_sel = HWDATA[`PDMC_WAKE_LSB +: 3];
                    n.soft_sby = HWDATA[`PDMC_SOFT_SBY_BIT];
                end
                default: begin
                    n.soft_sby = r.soft_sby;  // Unmapped and read-only: ignored
                end
            endcase
        end

        // Control registers return to their reset values while held in reset
        if (n.st == PDMC_HW_STANDBY || n.st == PDMC_RESET_HOLD) begin
            n.halt_a   = `PDMC_HALT_A_RST;  // R8
            n.halt_b   = `PDMC_HALT_B_RST;  // R8
            n.clk_halt = `PDMC_CLK_HALT_RST;
            n.port_dir = `PDMC_PORT_DIR_RST;
            n.div_sel  = `PDMC_DIV_RST;
            n.wake_sel = `PDMC_WAKE_RST;
            n.soft_sby = `PDMC_SOFT_SBY_RST;
        end

        // Address phase capture; read data built from post-write values
        n.rdata = 32'h0;
        if (addr_ok) begin
            n.dph_wr   = HWRITE;
            n.dph_addr = HADDR;
            if (!HWRITE) begin
                case (HADDR)
                    `PDMC_OFS_HALT_A: n.rdata = {16'h0, n.halt_a};
                    `PDMC_OFS_HALT_B: n.rdata = {24'h0, n.halt_b};
                    `PDMC_OFS_CLK_CTRL: begin
                        n.rdata[`PDMC_CLK_HALT_BIT]  = n.clk_halt;
                        n.rdata[`PDMC_PORT_DIR_BIT]  = n.port_dir;
                        n.rdata[`PDMC_DIV_LSB +: 3]  = n.div_sel;
                    end
                    `PDMC_OFS_LOW_POWER: begin
                        n.rdata[`PDMC_WAKE_LSB +: 3] = n.wake_sel;
                        n.rdata[`PDMC_SOFT_SBY_BIT]  = n.soft_sby;
                    end
                    `PDMC_OFS_STATUS: begin
                        n.rdata[2:0] = r.st;
                        n.rdata[3]   = r.phi_s[1];
                    end
                    default: n.rdata = 32'h0;
                endcase
            end
        end
        n.clear = clear_nxt;
    end

    // ==================================================================
    // State register
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            r          <= '0;
            r.st       <= PDMC_HW_STANDBY;
            r.sleep_s  <= 2'h0;
            r.init_s   <= 2'h0;
            r.halt_a   <= `PDMC_HALT_A_RST;  // R8
            r.halt_b   <= `PDMC_HALT_B_RST;  // R8
            r.clear    <= `PDMC_NO_RETAIN_RST;
        end else begin
            r <= n;
        end
    end

    // ==================================================================
    // Bus answers: zero wait state, always OKAY
    assign HREADYOUT = 1'h1;
    assign HRESP     = 1'h0;
    assign HRDATA    = r.rdata;

    // ==================================================================
    // System outputs decoded from the state register
    assign SYS_RESET_N = ~(r.st == PDMC_HW_STANDBY || r.st == PDMC_RESET_HOLD);  // R19
    assign RESET_EXC   = r.st == PDMC_RESET_EXC;  // R3
    assign CPU_RUN     = r.st == PDMC_RUN;
    assign OSC_EN      = ~(r.st == PDMC_HW_STANDBY || r.st == PDMC_SW_STANDBY);  // R1
    assign PORT_HIZ    = r.st == PDMC_HW_STANDBY;  // R19
    assign PORT_HOLD   = r.st == PDMC_SW_STANDBY || r.st == PDMC_WAKE_WAIT;  // R14
    assign PERIPH_TICK = r.tick;  // R18

    // ==================================================================
    // Unit halt and access gating; halts never touch the processor
    assign UNIT_HALT        = {r.halt_b, r.halt_a};  // R5 R6
    assign UNIT_ACCESS_EN   = ~{r.halt_b, r.halt_a};  // R9
    assign UNIT_STATE_CLEAR = r.clear;  // R7

    // ==================================================================
    // Clock output pin; tristate when an input or in hardware standby
    assign PHI_OE = r.port_dir & (r.st != PDMC_HW_STANDBY);  // R11 R12 R13
    assign PHI_O  = (r.clk_halt || PORT_HOLD) ? 1'h1 : r.phi;  // R10 R11 R13
endmodule

// File: tb/pdmc_pins.sv
// Board pin driver model: standby pin, init pin and the far side of the clock pin
`timescale 1ns/100ps
module pdmc_pins #(
    parameter int SETTLE = 20
) (
    // Clock and clock pin
    input  wire logic clk,
    input  wire logic phi_o,
    input  wire logic phi_oe,
    // Pins to the device
    output logic      sleep_n,
    output logic      init_n,
    output logic      phi_i
);
    logic alt_r = 1'b0;

    // =========
    // Released clock pin shows a moving pattern, never a held value
    always_ff @(posedge clk) alt_r <= ~alt_r;
    assign phi_i = phi_oe ? phi_o : alt_r;

    // Power-up with both pins low
    initial begin
        sleep_n = 1'b0;
        init_n = 1'b0;
    end

    // =========
    // Leave standby: deep-sleep first, init held low while the oscillator settles
    task automatic leave_standby();
        @(posedge clk);
        sleep_n <= 1'b1;
        repeat (SETTLE) @(posedge clk);
        init_n <= 1'b1;
    endtask

    // Enter standby: init low strictly before deep-sleep low
    task automatic enter_standby();
        @(posedge clk);
        init_n <= 1'b0;
        repeat (8) @(posedge clk);
        sleep_n <= 1'b0;
    endtask
endmodule

// File: tb/pdmc_top_asserts.sv
// Port-level concurrent checks of the power-down mode controller
`timescale 1ns/100ps
`include "pdmc_defines.svh"
module pdmc_asserts #(
    parameter logic [`PDMC_UNITS-1:0] NO_RETAIN_MASK = `PDMC_NO_RETAIN_RST
) (
    // Clock and reset
    input wire logic                   CLK,
    input wire logic                   ARST_N,
    // Pins
    input wire logic                   DEEP_SLEEP_PIN_N,
    input wire logic                   EXTERNAL_INIT_PIN_N,
    input wire logic                   PHI_O,
    input wire logic                   PHI_OE,
    // System control
    input wire logic                   SYS_RESET_N,
    input wire logic                   RESET_EXC,
    input wire logic                   CPU_RUN,
    input wire logic                   OSC_EN,
    input wire logic                   PORT_HIZ,
    input wire logic                   PORT_HOLD,
    input wire logic                   PERIPH_TICK,
    // Units
    input wire logic [`PDMC_UNITS-1:0] UNIT_HALT,
    input wire logic [`PDMC_UNITS-1:0] UNIT_ACCESS_EN,
    input wire logic [`PDMC_UNITS-1:0] UNIT_STATE_CLEAR
);
    // =========
    // One domain; pins pass two sync stages, so windows allow 2 to 4 edges
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    property p_access_inv; UNIT_ACCESS_EN == ~UNIT_HALT; endproperty
    a_access_inv: assert property (p_access_inv) else $error("access enable not halt inverse");
    property p_hiz; PORT_HIZ |-> !PHI_OE && !SYS_RESET_N && !OSC_EN && (&UNIT_HALT); endproperty
    a_hiz: assert property (p_hiz) else $error("standby outputs wrong");
    property p_hold_high; PORT_HOLD |-> PHI_O && !PORT_HIZ; endproperty
    a_hold_high: assert property (p_hold_high) else $error("clock pin not high in hold");
    property p_exc_len; $rose(RESET_EXC) |-> RESET_EXC [*8] ##1 (!RESET_EXC && CPU_RUN); endproperty
    a_exc_len: assert property (p_exc_len) else $error("reset handling phase length");
    property p_enter; $fell(DEEP_SLEEP_PIN_N) |-> ##[2:4] PORT_HIZ; endproperty
    a_enter: assert property (p_enter) else $error("standby not entered");
    property p_wake;
        $rose(DEEP_SLEEP_PIN_N) && !EXTERNAL_INIT_PIN_N |->
            ##[2:4] (OSC_EN && !PORT_HIZ && !SYS_RESET_N);
    endproperty
    a_wake: assert property (p_wake) else $error("standby not left into reset");
    property p_init_low; CPU_RUN && $fell(EXTERNAL_INIT_PIN_N) |-> ##[2:4] !SYS_RESET_N; endproperty
    a_init_low: assert property (p_init_low) else $error("init pin not obeyed");
    property p_keep; (UNIT_STATE_CLEAR & ~NO_RETAIN_MASK) == '0; endproperty
    a_keep: assert property (p_keep) else $error("retaining unit cleared");
    // Clear register follows the halt register of the same cycle while running
    property p_clear; CPU_RUN |-> UNIT_STATE_CLEAR == (UNIT_HALT & NO_RETAIN_MASK);
    endproperty
    a_clear: assert property (p_clear) else $error("state clear of halted unit wrong");
    property p_tick; PERIPH_TICK |=> !PERIPH_TICK; endproperty
    a_tick: assert property (p_tick) else $error("tick longer than one cycle");

    // Main scenarios reached
    c_run: cover property ($rose(CPU_RUN));
    c_soft: cover property (PORT_HOLD ##1 !PORT_HOLD);
    c_hard: cover property ($rose(PORT_HIZ));
endmodule

bind pdmc_top pdmc_asserts #(.NO_RETAIN_MASK(NO_RETAIN_MASK)) u_chk (
    .CLK(CLK), .ARST_N(ARST_N), .DEEP_SLEEP_PIN_N(DEEP_SLEEP_PIN_N),
    .EXTERNAL_INIT_PIN_N(EXTERNAL_INIT_PIN_N), .PHI_O(PHI_O), .PHI_OE(PHI_OE),
    .SYS_RESET_N(SYS_RESET_N), .RESET_EXC(RESET_EXC), .CPU_RUN(CPU_RUN), .OSC_EN(OSC_EN),
    .PORT_HIZ(PORT_HIZ), .PORT_HOLD(PORT_HOLD), .PERIPH_TICK(PERIPH_TICK),
    .UNIT_HALT(UNIT_HALT), .UNIT_ACCESS_EN(UNIT_ACCESS_EN), .UNIT_STATE_CLEAR(UNIT_STATE_CLEAR)
);

// File: tb/tb.sv
// Self-checking bench of the power-down mode controller
`timescale 1ns/100ps
module tb;
    logic        clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        sleep_req = 1'b0, wake_irq = 1'b0, last;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, rd, v;
    logic        hreadyout, hresp, phi_o, phi_oe, phi_i, sleep_n, init_n;
    logic        sys_reset_n, reset_exc, cpu_run, osc_en, port_hiz, port_hold, tick;
    logic [23:0] halt, acc, clr;
    int          miscompares = 0, n_checks = 0, cycles = 0, n;
    int          dv[4] = '{0, 1, 2, 7};

    // =========
    // 250 MHz clock and a cycle ceiling against hangs
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            stop_test();
        end
    end

    pdmc_top #(.WAKE_BASE(16)) DUT (.CLK(clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .DEEP_SLEEP_PIN_N(sleep_n),
        .EXTERNAL_INIT_PIN_N(init_n), .PHI_I(phi_i), .PHI_O(phi_o), .PHI_OE(phi_oe),
        .SLEEP_REQ(sleep_req), .WAKE_IRQ(wake_irq), .SYS_RESET_N(sys_reset_n),
        .RESET_EXC(reset_exc), .CPU_RUN(cpu_run), .OSC_EN(osc_en), .PORT_HIZ(port_hiz),
        .PORT_HOLD(port_hold), .PERIPH_TICK(tick), .UNIT_HALT(halt), .UNIT_ACCESS_EN(acc),
        .UNIT_STATE_CLEAR(clr));
    pdmc_pins pins (.clk(clk), .phi_o(phi_o), .phi_oe(phi_oe), .sleep_n(sleep_n),
        .init_n(init_n), .phi_i(phi_i));

    // =========
    // Comparison, verdict and bus cycles; the bench is the only writer, as the CPU
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wait_run();
        n = 0;
        while (cpu_run !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        chk(cpu_run, 1);
    endtask
    function automatic int ticks_exp(input int code, input int cyc);
        return cyc / ((code == 1 || code == 2) ? (2 << code) : 2);
    endfunction

    initial begin
        void'($urandom(32'hade32a7e));
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        // Reset values; writes before run are refused
        bus(8'h00, 1'b1, 32'h0);
        bus(8'h00, 1'b0, 32'h0);
        chk(rd, 32'h0000ffff);
        chk(halt, 24'hffffff);
        chk({phi_oe, port_hiz}, 2'b01);
        pins.leave_standby();
        wait_run();
        bus(8'h10, 1'b1, 32'h0);
        bus(8'h10, 1'b0, 32'h0);
        chk(rd[2:0], 3'h3);
        bus(8'h14, 1'b0, 32'h0);
        chk(rd, 32'h0);
        // Random halt patterns with all-run and all-stop corners
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 32'h0 : (i == 1) ? 32'hffffffff : $urandom;
            bus(8'h00, 1'b1, v);
            bus(8'h04, 1'b1, v >> 16);
            @(negedge clk);
            chk(halt, v[23:0]);
            chk(acc, {8'h00, ~v[23:0]});
            @(negedge clk);
            chk(clr, v[23:0] & 24'hff0000);
            bus(8'h04, 1'b0, 32'h0);
            chk(rd, {24'h0, v[23:16]});
            chk(hresp, 1'b0);
        end
        // Clock pin for each direction and halt setting
        for (int k = 0; k < 4; k++) begin
            bus(8'h08, 1'b1, k);
            repeat (4) @(negedge clk);
            n = 0;
            last = phi_o;
            repeat (16) begin
                @(negedge clk);
                if (phi_o !== last) n++;
                last = phi_o;
            end
            chk(phi_oe, k[1]);
            chk(n > 0, !k[0]);
            if (k[0]) chk(phi_o, 1);
            if (k[1]) chk(phi_i, phi_o);
        end
        // Divide codes, slowest kept at 31.25 MHz
        foreach (dv[j]) begin
            bus(8'h08, 1'b1, {dv[j][2:0], 4'h2});
            repeat (16) @(negedge clk);
            n = 0;
            repeat (48) begin
                @(negedge clk);
                if (tick === 1'b1) n++;
            end
            chk(n, ticks_exp(dv[j], 48));
        end
        bus(8'h08, 1'b1, 32'h2);
        // Software standby with the shortest allowed wake wait, 16 states at this base
        bus(8'h0c, 1'b1, 32'h80);
        @(posedge clk);
        sleep_req <= 1'b1;
        @(posedge clk);
        sleep_req <= 1'b0;
        n = 0;
        while (port_hold !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        chk({port_hold, phi_o, osc_en}, 3'b110);
        chk(halt, v[23:0]);
        @(posedge clk);
        wake_irq <= 1'b1;
        wait_run();
        wake_irq <= 1'b0;
        chk(n >= 32, 1);
        // Hardware standby and the reset values after it
        pins.enter_standby();
        repeat (6) @(negedge clk);
        chk({port_hiz, phi_oe, sys_reset_n}, 3'b100);
        chk(halt, 24'hffffff);
        pins.leave_standby();
        wait_run();
        bus(8'h08, 1'b0, 32'h0);
        chk(rd, 32'h0);
        stop_test();
    end
endmodule
